// [core/cba_pkg.sv]
package cba_pkg;
  // Register regions, selected by address bits [11:10]
  localparam logic [1:0] REGION_ATTR = 2'h0;
  localparam logic [1:0] REGION_SYND = 2'h1;
  localparam logic [1:0] REGION_EXT = 2'h2;
  localparam logic [11:0] ATTR_BASE = 12'h000;
  localparam logic [11:0] SYND_BASE = 12'h400;
  localparam logic [11:0] EXT_BASE = 12'h800;
  localparam int ADDR_W = 12;
  localparam int REGION_LSB = 10;
  localparam int INDEX_LSB = 2;
  localparam int INDEX_W = 8;
  // Attribute register fields
  localparam int IRQ_IDX_LSB = 24;
  localparam int TYPE_LSB = 16;
  localparam int S2_IDX_LSB = 8;
  localparam int HYP_BIT = 10;
  localparam int VMID8_LSB = 0;
  // Extended attribute register fields
  localparam int WIDE_VMID_LSB = 16;
  localparam int MONITOR_CONTEXT_BIT = 1;
  localparam int AW64_BIT = 0;
  // Syndrome register fields
  localparam int SDI_LSB = 16;
  localparam int SID_LSB = 0;
  // Reset values
  localparam logic [31:0] ATTR_RST = 32'h0000_0000;
  localparam logic [31:0] EXT_RST = 32'h0000_0000;
  localparam logic [31:0] SYND_RST = 32'h0000_0000;
  // Context types
  localparam logic [1:0] TYPE_S2_ONLY = 2'h0;
  localparam logic [1:0] TYPE_S1_BYPASS = 2'h1;
  localparam logic [1:0] TYPE_S1_FAULT = 2'h2;
  localparam logic [1:0] TYPE_NESTED = 2'h3;
  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_RD_WAIT, BUS_RD_DONE} cba_bus_e;
endpackage : cba_pkg

// [core/cba_bus_if.sv]
`timescale 1ns/1ps
interface cba_bus_if;
  logic wr;
  logic [1:0] region;
  logic [7:0] index;
  logic [31:0] wdata;
  logic nonsec;
  logic [31:0] rdata;
  modport slave (output wr, region, index, wdata, nonsec, input rdata);
  modport regs (input wr, region, index, wdata, nonsec, output rdata);
endinterface : cba_bus_if

// [core/cba_ahb_slave.sv]
`timescale 1ns/1ps
module cba_ahb_slave
  import cba_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hnonsec,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  cba_bus_if.slave bus
);
  cba_bus_e state_q;
  cba_bus_e state_d;
  logic [ADDR_W-1:0] addr_q;
  logic nonsec_q;
  logic [31:0] rdata_q;
  wire take = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire word = (hsize == 3'h2);

  // Word reads take one wait state so a preceding write is visible
  always_comb
  begin
    unique case (state_q)
      BUS_IDLE: state_d = take ? (hwrite ? BUS_WRITE : BUS_RD_WAIT) : BUS_IDLE;
      BUS_WRITE: state_d = take ? (hwrite ? BUS_WRITE : BUS_RD_WAIT) : BUS_IDLE;
      BUS_RD_WAIT: state_d = BUS_RD_DONE;
      BUS_RD_DONE: state_d = take ? (hwrite ? BUS_WRITE : BUS_RD_WAIT) : BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= BUS_IDLE;
      addr_q <= '0;
      nonsec_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      state_q <= (take & ~word) ? BUS_IDLE : state_d;
      if (take)
      begin
        addr_q <= haddr;
        nonsec_q <= hnonsec;
      end
      if (state_q == BUS_RD_WAIT)
        rdata_q <= bus.rdata;
    end
  end

  assign bus.wr = (state_q == BUS_WRITE);
  assign bus.region = addr_q[REGION_LSB +: 2];
  assign bus.index = addr_q[INDEX_LSB +: INDEX_W];
  assign bus.wdata = hwdata;
  assign bus.nonsec = nonsec_q;
  assign hreadyout = (state_q != BUS_RD_WAIT);
  assign hrdata = rdata_q;
  assign hresp = HRESP_OKAY;
endmodule : cba_ahb_slave

// [core/cba_lookup.sv]
`timescale 1ns/1ps
module cba_lookup
  import cba_pkg::*;
#(
  parameter int NUM_BANKS = 8,
  parameter int BANK_IDX_W = 3
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [BANK_IDX_W-1:0] bank,
  input wire logic wide_en,
  input wire logic ext_addr_en,
  input wire logic [NUM_BANKS-1:0] secure,
  input wire logic [NUM_BANKS-1:0][1:0] ctx_type,
  input wire logic [NUM_BANKS-1:0] hyp,
  input wire logic [NUM_BANKS-1:0][BANK_IDX_W-1:0] s2_idx,
  input wire logic [NUM_BANKS-1:0][7:0] vmid8,
  input wire logic [NUM_BANKS-1:0][15:0] wide_vmid,
  input wire logic [NUM_BANKS-1:0] monitor_context,
  input wire logic [NUM_BANKS-1:0] aw64,
  output logic invalid_ctx,
  output logic stage2_en,
  output logic [BANK_IDX_W-1:0] stage2_bank,
  output logic [15:0] vm_id,
  output logic tag_suppress,
  output logic fmt_64,
  output logic long_desc
);
  wire [1:0] t = ctx_type[bank];
  wire hyp32 = (t == TYPE_S1_BYPASS) & hyp[bank];
  wire mon_eff = monitor_context[bank] & aw64[bank] & (t == TYPE_S1_BYPASS) & secure[bank];
  wire aw_eff = aw64[bank] & ~hyp32;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      invalid_ctx <= 1'b0;
      stage2_en <= 1'b0;
      stage2_bank <= '0;
      vm_id <= 16'h0000;
      tag_suppress <= 1'b0;
      fmt_64 <= 1'b0;
      long_desc <= 1'b0;
    end
    else
    begin
      invalid_ctx <= (t == TYPE_S1_FAULT);
      stage2_en <= (t == TYPE_NESTED);
      stage2_bank <= (t == TYPE_NESTED) ? s2_idx[bank] : '0;
      vm_id <= wide_en ? wide_vmid[bank] : {8'h00, vmid8[bank]};
      tag_suppress <= mon_eff | hyp32;
      fmt_64 <= aw_eff;
      long_desc <= aw_eff | ext_addr_en;
    end
  end
endmodule : cba_lookup

// [core/cba_regs.sv]
`timescale 1ns/1ps
module cba_regs
  import cba_pkg::*;
#(
  parameter int NUM_BANKS = 8,
  parameter int BANK_IDX_W = 3,
  parameter int IRQ_W = 8,
  parameter int SID_W = 16,
  parameter int SDI_W = 16,
  parameter bit TWO_SEC = 1'b1,
  parameter bit ONLY_64 = 1'b0
)
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [ADDR_W-1:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HNONSEC,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  input wire logic WIDE_VM_ID_ENABLE,
  input wire logic WIDE_VM_ID_SUPPORTED,
  input wire logic [NUM_BANKS-1:0] BANK_SECURE,
  input wire logic [NUM_BANKS-1:0] SECURITY_CHANGE,
  input wire logic [NUM_BANKS-1:0] BANK_STALLED,
  output logic [NUM_BANKS-1:0] RETRY_STALLED,
  input wire logic FAULT_VALID,
  input wire logic [BANK_IDX_W-1:0] FAULT_BANK,
  input wire logic [15:0] FAULT_STREAM_IDENTIFIER,
  input wire logic [15:0] FAULT_SECURITY_DESCRIPTOR_INDEX,
  input wire logic FAULT_TRANSLATION_OP,
  output logic [NUM_BANKS-1:0] CONTEXT_IRQ,
  output logic CONTEXT_IRQ_VALID,
  output logic [IRQ_W-1:0] CONTEXT_IRQ_INDEX,
  input wire logic [BANK_IDX_W-1:0] LOOKUP_BANK,
  input wire logic LOOKUP_EXTENDED_ADDRESS_ENABLE,
  output logic LOOKUP_INVALID_CONTEXT,
  output logic LOOKUP_STAGE2_ENABLE,
  output logic [BANK_IDX_W-1:0] LOOKUP_STAGE2_BANK,
  output logic [15:0] LOOKUP_VM_ID,
  output logic LOOKUP_TAG_SUPPRESS,
  output logic LOOKUP_FORMAT_64,
  output logic LOOKUP_LONG_DESCRIPTOR
);
  cba_bus_if bus ();

  logic [NUM_BANKS-1:0][IRQ_W-1:0] irq_idx_q;
  logic [NUM_BANKS-1:0][1:0] type_q;
  logic [NUM_BANKS-1:0] hyp_q;
  logic [NUM_BANKS-1:0][BANK_IDX_W-1:0] s2_idx_q;
  logic [NUM_BANKS-1:0][7:0] vmid8_q;
  logic [NUM_BANKS-1:0][15:0] wide_vmid_q;
  logic [NUM_BANKS-1:0] monitor_context_q;
  logic [NUM_BANKS-1:0] aw64_q;
  logic [NUM_BANKS-1:0][SID_W-1:0] sid_q;
  logic [NUM_BANKS-1:0][SDI_W-1:0] sdi_q;
  logic [NUM_BANKS-1:0] retry_q;
  logic [NUM_BANKS-1:0] irq_q;
  logic irq_valid_q;
  logic [IRQ_W-1:0] irq_index_q;

  wire wide_en = WIDE_VM_ID_ENABLE & WIDE_VM_ID_SUPPORTED;
  wire idx_ok = (bus.index < 8'(NUM_BANKS));
  wire [BANK_IDX_W-1:0] sel = bus.index[BANK_IDX_W-1:0];
  wire wr_attr = bus.wr & idx_ok & (bus.region == REGION_ATTR);
  wire wr_ext = bus.wr & idx_ok & (bus.region == REGION_EXT);
  wire wr_synd = bus.wr & idx_ok & (bus.region == REGION_SYND);
  wire [1:0] new_type = bus.wdata[TYPE_LSB +: 2];
  wire fault_record = FAULT_VALID & ~FAULT_TRANSLATION_OP;

  cba_ahb_slave u_slave (
    .clk(MCLK),
    .rst(RST),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hsize(HSIZE),
    .hnonsec(HNONSEC),
    .hwdata(HWDATA),
    .hready(HREADY),
    .hreadyout(HREADYOUT),
    .hrdata(HRDATA),
    .hresp(HRESP),
    .bus(bus.slave)
  );

  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b++)
    begin : g_bank
      wire hit = (sel == BANK_IDX_W'(b));
      wire fault_hit = fault_record & (FAULT_BANK == BANK_IDX_W'(b));

      // Attribute register
      always_ff @(posedge MCLK or posedge RST)
      begin
        if (RST)
        begin
          irq_idx_q[b] <= ATTR_RST[IRQ_IDX_LSB +: IRQ_W];
          type_q[b] <= ATTR_RST[TYPE_LSB +: 2];
          hyp_q[b] <= ATTR_RST[HYP_BIT];
          s2_idx_q[b] <= ATTR_RST[S2_IDX_LSB +: BANK_IDX_W];
          vmid8_q[b] <= ATTR_RST[VMID8_LSB +: 8];
        end
        else if (wr_attr & hit)
        begin
          irq_idx_q[b] <= bus.wdata[IRQ_IDX_LSB +: IRQ_W];
          type_q[b] <= new_type;
          hyp_q[b] <= (new_type == TYPE_S1_BYPASS) & bus.wdata[HYP_BIT];
          s2_idx_q[b] <= (new_type == TYPE_NESTED) ?
            bus.wdata[S2_IDX_LSB +: BANK_IDX_W] : '0;
          vmid8_q[b] <= wide_en ? 8'h00 : bus.wdata[VMID8_LSB +: 8];
        end
      end

      // Extended attribute register
      always_ff @(posedge MCLK or posedge RST)
      begin
        if (RST)
        begin
          wide_vmid_q[b] <= EXT_RST[WIDE_VMID_LSB +: 16];
          monitor_context_q[b] <= EXT_RST[MONITOR_CONTEXT_BIT];
          aw64_q[b] <= EXT_RST[AW64_BIT];
          retry_q[b] <= 1'b0;
        end
        else
        begin
          retry_q[b] <= wr_ext & hit & BANK_STALLED[b];
          if (wr_ext & hit)
          begin
            wide_vmid_q[b] <= wide_en ? bus.wdata[WIDE_VMID_LSB +: 16] : 16'h0000;
            monitor_context_q[b] <= TWO_SEC & bus.wdata[MONITOR_CONTEXT_BIT];
            aw64_q[b] <= bus.wdata[AW64_BIT];
          end
          else if (SECURITY_CHANGE[b])
            aw64_q[b] <= EXT_RST[AW64_BIT];
        end
      end

      // Syndrome register, a recorded fault wins over a software write
      always_ff @(posedge MCLK or posedge RST)
      begin
        if (RST)
        begin
          sid_q[b] <= SYND_RST[SID_LSB +: SID_W];
          sdi_q[b] <= SYND_RST[SDI_LSB +: SDI_W];
        end
        else if (fault_hit)
        begin
          sid_q[b] <= FAULT_STREAM_IDENTIFIER[SID_W-1:0];
          sdi_q[b] <= FAULT_SECURITY_DESCRIPTOR_INDEX[SDI_W-1:0];
        end
        else if (wr_synd & hit)
        begin
          sid_q[b] <= bus.wdata[SID_LSB +: SID_W];
          if (!bus.nonsec)
            sdi_q[b] <= bus.wdata[SDI_LSB +: SDI_W];
        end
      end
    end
  endgenerate

  // Read data of the selected bank
  wire [31:0] rd_attr = {IRQ_W'(irq_idx_q[sel]), 6'h00, type_q[sel],
    (type_q[sel] == TYPE_NESTED) ? 8'(s2_idx_q[sel]) :
    {5'h00, hyp_q[sel], 2'h0}, wide_en ? 8'h00 : vmid8_q[sel]};
  wire [31:0] rd_ext = {wide_en ? wide_vmid_q[sel] : 16'h0000, 14'h0000,
    monitor_context_q[sel] & TWO_SEC, aw64_q[sel] | ONLY_64};
  wire [31:0] rd_synd = {bus.nonsec ? 16'h0000 : 16'(sdi_q[sel]), 16'(sid_q[sel])};
  assign bus.rdata = !idx_ok ? 32'h0000_0000 :
    (bus.region == REGION_ATTR) ? rd_attr :
    (bus.region == REGION_EXT) ? rd_ext :
    (bus.region == REGION_SYND) ? rd_synd : 32'h0000_0000;

  // Fault interrupt, dedicated line per bank plus numbered index
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      irq_q <= '0;
      irq_valid_q <= 1'b0;
      irq_index_q <= '0;
    end
    else
    begin
      irq_q <= FAULT_VALID ? (NUM_BANKS'(1) << FAULT_BANK) : '0;
      irq_valid_q <= FAULT_VALID;
      irq_index_q <= FAULT_VALID ? irq_idx_q[FAULT_BANK] : irq_index_q;
    end
  end

  assign CONTEXT_IRQ = irq_q;
  assign CONTEXT_IRQ_VALID = irq_valid_q;
  assign CONTEXT_IRQ_INDEX = irq_index_q;
  assign RETRY_STALLED = retry_q;

  logic [NUM_BANKS-1:0] aw64_eff;
  assign aw64_eff = aw64_q | {NUM_BANKS{ONLY_64}};

  cba_lookup #(
    .NUM_BANKS(NUM_BANKS),
    .BANK_IDX_W(BANK_IDX_W)
  ) u_lookup (
    .clk(MCLK),
    .rst(RST),
    .bank(LOOKUP_BANK),
    .wide_en(wide_en),
    .ext_addr_en(LOOKUP_EXTENDED_ADDRESS_ENABLE),
    .secure(BANK_SECURE),
    .ctx_type(type_q),
    .hyp(hyp_q),
    .s2_idx(s2_idx_q),
    .vmid8(vmid8_q),
    .wide_vmid(wide_vmid_q),
    .monitor_context(monitor_context_q),
    .aw64(aw64_eff),
    .invalid_ctx(LOOKUP_INVALID_CONTEXT),
    .stage2_en(LOOKUP_STAGE2_ENABLE),
    .stage2_bank(LOOKUP_STAGE2_BANK),
    .vm_id(LOOKUP_VM_ID),
    .tag_suppress(LOOKUP_TAG_SUPPRESS),
    .fmt_64(LOOKUP_FORMAT_64),
    .long_desc(LOOKUP_LONG_DESCRIPTOR)
  );
endmodule : cba_regs

// [dv/cba_regs_assertions.sv]
`timescale 1ns/1ps
module cba_regs_assertions
  import cba_pkg::*;
#(
  parameter int NUM_BANKS = 8,
  parameter int BANK_IDX_W = 3
)
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic WIDE_VM_ID_ENABLE,
  input wire logic [NUM_BANKS-1:0] RETRY_STALLED,
  input wire logic FAULT_VALID,
  input wire logic [BANK_IDX_W-1:0] FAULT_BANK,
  input wire logic [NUM_BANKS-1:0] CONTEXT_IRQ,
  input wire logic CONTEXT_IRQ_VALID,
  input wire logic LOOKUP_INVALID_CONTEXT,
  input wire logic LOOKUP_STAGE2_ENABLE,
  input wire logic [15:0] LOOKUP_VM_ID
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_take;
    HSEL && HREADY && HTRANS == HTRANS_NONSEQ && HSIZE == 3'h2;
  endsequence
  sequence s_read_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  property p_read_phase;
    s_take ##0 !HWRITE |=> s_read_wait;
  endproperty
  property p_write_phase;
    s_take ##0 HWRITE |=> HREADYOUT;
  endproperty
  property p_okay;
    HRESP == HRESP_OKAY;
  endproperty
  property p_irq_bank;
    FAULT_VALID |=> CONTEXT_IRQ[$past(FAULT_BANK)] && $onehot(CONTEXT_IRQ);
  endproperty
  property p_irq_valid;
    FAULT_VALID |=> CONTEXT_IRQ_VALID;
  endproperty
  property p_irq_quiet;
    !FAULT_VALID |=> CONTEXT_IRQ == '0 && !CONTEXT_IRQ_VALID;
  endproperty
  property p_type_excl;
    LOOKUP_INVALID_CONTEXT |-> !LOOKUP_STAGE2_ENABLE;
  endproperty
  property p_narrow_id;
    !WIDE_VM_ID_ENABLE |=> LOOKUP_VM_ID[15:8] == 8'h00;
  endproperty
  property p_retry_one;
    $onehot0(RETRY_STALLED);
  endproperty
  a_read_phase: assert property (p_read_phase) else $error("read wait state wrong");
  a_write_phase: assert property (p_write_phase) else $error("write stalled");
  a_okay: assert property (p_okay) else $error("response not okay");
  a_irq_bank: assert property (p_irq_bank) else $error("wrong bank interrupt");
  a_irq_valid: assert property (p_irq_valid) else $error("interrupt valid missing");
  a_irq_quiet: assert property (p_irq_quiet) else $error("spurious interrupt");
  a_type_excl: assert property (p_type_excl) else $error("fault and chain together");
  a_narrow_id: assert property (p_narrow_id) else $error("narrow id upper bits set");
  a_retry_one: assert property (p_retry_one) else $error("retry on several banks");
endmodule : cba_regs_assertions

bind cba_regs cba_regs_assertions #(.NUM_BANKS(NUM_BANKS), .BANK_IDX_W(BANK_IDX_W))
  i_cba_regs_assertions (.MCLK(MCLK), .RST(RST), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HSIZE(HSIZE), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .WIDE_VM_ID_ENABLE(WIDE_VM_ID_ENABLE), .RETRY_STALLED(RETRY_STALLED),
  .FAULT_VALID(FAULT_VALID), .FAULT_BANK(FAULT_BANK), .CONTEXT_IRQ(CONTEXT_IRQ),
  .CONTEXT_IRQ_VALID(CONTEXT_IRQ_VALID), .LOOKUP_INVALID_CONTEXT(LOOKUP_INVALID_CONTEXT),
  .LOOKUP_STAGE2_ENABLE(LOOKUP_STAGE2_ENABLE), .LOOKUP_VM_ID(LOOKUP_VM_ID));

// [dv/cba_regs_tb_top.sv]
`timescale 1ns/1ps
module cba_regs_tb_top
  import cba_pkg::*;
;
  logic mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hnonsec = 1'b0;
  logic [11:0] haddr = '0, ofs;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = '0, fbank = '0, lbank = '0;
  logic [31:0] hwdata = '0, rd, w;
  logic wide_en = 1'b0, fvalid = 1'b0, ftop = 1'b0, eae = 1'b1;
  logic [7:0] secure = '0, sec_chg = '0, stalled = '0;
  logic [15:0] fsid = '0, fsdi = '0;
  wire hready, hreadyout, hresp, irq_valid, l_inv, l_s2, l_fmt, l_long, l_tag;
  wire [31:0] hrdata;
  wire [7:0] retry, irq, irq_idx;
  wire [2:0] l_s2b;
  wire [15:0] l_vm;
  int miscompares = 0, cmp_count = 0, cycles = 0, k;
  assign hready = hreadyout;
  always #5 mclk = ~mclk;
  cba_regs i_cba_regs (.MCLK(mclk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HNONSEC(hnonsec), .HWDATA(hwdata), .HREADY(hready),
    .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp), .WIDE_VM_ID_ENABLE(wide_en),
    .WIDE_VM_ID_SUPPORTED(1'b1), .BANK_SECURE(secure), .SECURITY_CHANGE(sec_chg),
    .BANK_STALLED(stalled), .RETRY_STALLED(retry), .FAULT_VALID(fvalid), .FAULT_BANK(fbank),
    .FAULT_STREAM_IDENTIFIER(fsid), .FAULT_SECURITY_DESCRIPTOR_INDEX(fsdi),
    .FAULT_TRANSLATION_OP(ftop), .CONTEXT_IRQ(irq), .CONTEXT_IRQ_VALID(irq_valid),
    .CONTEXT_IRQ_INDEX(irq_idx), .LOOKUP_BANK(lbank), .LOOKUP_EXTENDED_ADDRESS_ENABLE(eae),
    .LOOKUP_INVALID_CONTEXT(l_inv), .LOOKUP_STAGE2_ENABLE(l_s2), .LOOKUP_STAGE2_BANK(l_s2b),
    .LOOKUP_VM_ID(l_vm), .LOOKUP_TAG_SUPPRESS(l_tag), .LOOKUP_FORMAT_64(l_fmt),
    .LOOKUP_LONG_DESCRIPTOR(l_long));
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic ns);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    hnonsec <= ns;
    @(posedge mclk iff hready);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk iff hready);
    rd = hrdata;
  endtask : ahb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, 1'b0);
  endtask : wr
  task automatic chk_port(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_port
  task automatic chk_reg(input logic [11:0] a, input logic ns, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0, ns);
    chk_port(rd, exp, "register read");
  endtask : chk_reg
  task automatic lk(input logic [2:0] b);
    lbank <= b;
    repeat (2) @(posedge mclk);
  endtask : lk
  function automatic logic [31:0] attr_exp(input logic [31:0] d);
    logic [31:0] m;
    m = 32'hFF03_00FF;
    if (d[17:16] == TYPE_S1_BYPASS)
      m[HYP_BIT] = 1'b1;
    if (d[17:16] == TYPE_NESTED)
      m[10:8] = 3'h7;
    return d & m;
  endfunction : attr_exp
  function automatic logic [31:0] ext_exp(input logic [31:0] d, input logic wide);
    return {wide ? d[31:16] : 16'h0000, 14'h0000, d[1:0]};
  endfunction : ext_exp
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      print_verdict();
    end
  end
  initial
  begin
    void'($urandom(32'h06220A1C));
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk_reg(ATTR_BASE, 1'b0, ATTR_RST);
    chk_reg(EXT_BASE + 12'h01C, 1'b0, EXT_RST);
    chk_reg(SYND_BASE + 12'h004, 1'b0, SYND_RST);
    wr(ATTR_BASE + 12'h020, 32'hFFFF_FFFF);
    chk_reg(ATTR_BASE + 12'h020, 1'b0, 32'h0);
    chk_reg(12'hC00, 1'b0, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 12; i++)
    begin
      wide_en <= 1'b0;
      ofs = 12'(4 * $urandom_range(7, 0));
      w = $urandom();
      w[17:16] = (i % 3 == 2) ? TYPE_NESTED : 2'(i % 3);
      wr(ATTR_BASE + ofs, w);
      chk_reg(ATTR_BASE + ofs, 1'b0, attr_exp(w));
      wide_en <= i[0];
      w = $urandom();
      wr(EXT_BASE + ofs, w);
      chk_reg(EXT_BASE + ofs, 1'b0, ext_exp(w, i[0]));
      w = $urandom();
      wr(SYND_BASE + ofs, w);
      chk_reg(SYND_BASE + ofs, 1'b0, w);
      chk_reg(SYND_BASE + ofs, 1'b1, {16'h0000, w[15:0]});
      ahb(1'b1, SYND_BASE + ofs, ~w, 1'b1);
      chk_reg(SYND_BASE + ofs, 1'b0, {w[31:16], ~w[15:0]});
    end
    $display("test random access done");
    wide_en <= 1'b0;
    wr(ATTR_BASE + 12'h008, 32'h0003_053C);
    wr(ATTR_BASE + 12'h00C, 32'h0002_0000);
    wr(ATTR_BASE + 12'h014, 32'h0000_003C);
    wr(ATTR_BASE + 12'h010, 32'h0001_0000);
    wr(EXT_BASE + 12'h010, 32'h0000_0003);
    lk(3'h2);
    chk_port(32'(l_s2), 32'h1, "chain");
    chk_port(32'(l_s2b), 32'h5, "chain bank");
    chk_port(32'(l_vm), 32'h003C, "narrow id");
    lk(3'h3);
    chk_port(32'(l_inv), 32'h1, "invalid ctx");
    for (int s = 0; s < 2; s++)
    begin
      secure <= 8'(s) << 4;
      lk(3'h4);
      chk_port(32'(l_tag), 32'(s), "tag suppress");
    end
    wide_en <= 1'b1;
    wr(EXT_BASE + 12'h008, 32'hBEEF_0001);
    lk(3'h2);
    chk_port(32'(l_vm), 32'hBEEF, "wide id");
    chk_port(32'(l_fmt), 32'h1, "format 64");
    sec_chg <= 8'h04;
    @(posedge mclk);
    sec_chg <= 8'h00;
    chk_reg(EXT_BASE + 12'h008, 1'b0, 32'hBEEF_0000);
    lk(3'h2);
    chk_port({l_fmt, l_long}, 32'h1, "format select");
    $display("test lookup done");
    w = $urandom();
    wr(ATTR_BASE + 12'h004, w);
    for (int t = 0; t < 2; t++)
    begin
      fbank <= 3'h1;
      ftop <= t[0];
      fsid <= 16'($urandom());
      fsdi <= 16'($urandom());
      fvalid <= 1'b1;
      @(posedge mclk);
      fvalid <= 1'b0;
      @(posedge mclk);
      chk_port(32'(irq), 32'h02, "irq line");
      chk_port(32'(irq_idx), 32'(w[31:24]), "irq index");
      if (t == 0)
        chk_reg(SYND_BASE + 12'h004, 1'b0, {fsdi, fsid});
    end
    $display("test fault done");
    stalled <= 8'h04;
    wr(EXT_BASE + 12'h008, 32'h0);
    #1;
    k = 0;
    while (retry[2] !== 1'b1 && k < 4)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    chk_port(32'(retry), 32'h04, "retry");
    $display("test retry done");
    print_verdict();
  end
endmodule : cba_regs_tb_top
